// *** bias_config_pkg.sv ***
/*
  Shared constants for the bias configuration register bank: register
  offsets, field positions, factory defaults and the start-up delay step.
  Assumes a 250 MHz core clock and a byte-wide register access port.
*/
`default_nettype none

package bias_config_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MISC_CONFIGURATION_OFS = 8'h00;
  localparam logic [7:0] LOGIC_REGULATOR_LEVEL_OFS = 8'h01;
  localparam logic [7:0] LOGIC_REGULATOR_STARTUP_DELAY_OFS = 8'h02;

  // ----------------------------------------------------------------------
  // field positions of the configuration register
  // ----------------------------------------------------------------------
  localparam int ANALOG_RAILS_DISABLE_BIT = 7;
  localparam int DISCHARGE_INHIBIT_BIT = 3;
  localparam int WRITE_PROTECT_ENABLE_BIT = 2;
  localparam int DIMMING_SELECT_BIT = 1;
  localparam int RESET_THRESHOLD_SELECT_BIT = 0;

  // ----------------------------------------------------------------------
  // factory defaults and field widths
  // ----------------------------------------------------------------------
  localparam logic [7:0] MISC_CONFIGURATION_RST = 8'h02;
  localparam int LEVEL_WIDTH = 2;
  localparam logic [1:0] LOGIC_REGULATOR_LEVEL_RST = 2'h3;
  localparam int DELAY_WIDTH = 4;
  localparam logic [3:0] LOGIC_REGULATOR_STARTUP_DELAY_RST = 4'h2;

  // ----------------------------------------------------------------------
  // start-up delay timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_STEP_MS = 5;
  localparam int DELAY_STEP_CYCLES = (DELAY_STEP_MS * 1000000) / CLK_PERIOD_NS;

  // sequencing states
  typedef enum logic [2:0] {
    SEQ_LOAD = 3'h1,
    SEQ_WAIT = 3'h2,
    SEQ_RUN = 3'h4
  } seq_state_t;

endpackage

`default_nettype wire

// *** bias_config_regs.sv ***
/*
  Byte-wide configuration register bank with start-up sequencing of the
  logic regulator. Holds the configuration, regulator level and regulator
  start-up delay registers and drives their control outputs.
  Assumes a bus protocol engine on the same clock that presents one-cycle
  write and read strobes, and a nonvolatile loader that offers saved
  values with a load strobe and takes the save image from SAVE_DATA_O.
*/
`default_nettype none

// What this block does
// - The rail-disable bit 7 lives only in volatile storage and is masked out of the save image.
// - With rail-disable at 1 both boost converters and the charge pump are switched off.
// - Rail-disable is cleared at every power-up so the converters start enabled.
// - Configuration bit 3 at 1 disables the first boost converter's active discharge.
// - With bit 2 at 1 the interface answers only while the write-protect pin is low.
// - Configuration bit 1 selects direct (0) or phase-shifted (1) dimming.
// - Configuration bit 0 selects the undervoltage (0) or detect (1) reset threshold.
// - All eight configuration bits are read/write with a default of 02h.
// - Level register bits 7 to 2 drop write data and read as zero.
// - Level bits 1 to 0 pick 1.0, 1.2, 1.89 or 2.5 V and default to 3h.
// - Delay register holds a 4-bit field defaulting to 2h, upper bits read zero.
// - The delay code gives 5 ms per step from supply-good to regulator start.
module bias_config_regs #(
  parameter int STEP_CYCLES = bias_config_pkg::DELAY_STEP_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic WRITE_PROTECT_N_I,
  input wire logic SUPPLY_GOOD_I,
  input wire logic WR_EN_I,
  input wire logic RD_EN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic NV_LOAD_I,
  input wire logic [7:0] NV_CONFIG_I,
  input wire logic [7:0] NV_LEVEL_I,
  input wire logic [7:0] NV_DELAY_I,
  output logic [7:0] RDATA_O,
  output logic RDATA_VALID_O,
  output logic BUS_ACTIVE_O,
  output logic [7:0] SAVE_DATA_O,
  output logic BOOST1_ENABLE_O,
  output logic BOOST2_ENABLE_O,
  output logic CHARGE_PUMP_ENABLE_O,
  output logic DISCHARGE_INHIBIT_O,
  output logic DIMMING_SELECT_O,
  output logic RESET_THRESHOLD_SELECT_O,
  output logic [1:0] LEVEL_SELECT_O,
  output logic REGULATOR_ENABLE_O
);

  // ----------------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_meta_reg, rst_n;
  logic [1:0] wp_sync_reg, good_sync_reg;
  logic wp_n, supply_good;

  // reset asserts at once but releases two edges later
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wp_sync_reg <= 2'h3;
      good_sync_reg <= 2'h0;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], WRITE_PROTECT_N_I};
      good_sync_reg <= {good_sync_reg[0], SUPPLY_GOOD_I};
    end
  end
  assign wp_n = wp_sync_reg[1];
  assign supply_good = good_sync_reg[1];

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0] config_reg, config_next;
  logic [1:0] level_reg, level_next;
  logic [3:0] delay_reg, delay_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic active_reg, active_next;
  logic [7:0] save_reg, save_next;
  logic access_ok;

  // write protect gates every host access
  assign access_ok = !config_reg[bias_config_pkg::WRITE_PROTECT_ENABLE_BIT] || !wp_n;

  // next register values; a loader strobe wins over a host write
  always_comb begin
    config_next = config_reg;
    level_next = level_reg;
    delay_next = delay_reg;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    if (NV_LOAD_I) begin
      // rail-disable is forced to 0 on load, whatever the saved image carries
      config_next = {1'b0, NV_CONFIG_I[6:0]};
      level_next = NV_LEVEL_I[1:0];
      delay_next = NV_DELAY_I[3:0];
    end else if (WR_EN_I && access_ok) begin
      case (ADDR_I)
        bias_config_pkg::MISC_CONFIGURATION_OFS: config_next = WDATA_I;
        bias_config_pkg::LOGIC_REGULATOR_LEVEL_OFS: level_next = WDATA_I[1:0];
        bias_config_pkg::LOGIC_REGULATOR_STARTUP_DELAY_OFS: delay_next = WDATA_I[3:0];
        default: ;
      endcase
    end
    if (RD_EN_I && access_ok) begin
      rvalid_next = 1'b1;
      case (ADDR_I)
        bias_config_pkg::MISC_CONFIGURATION_OFS: rdata_next = config_reg;
        bias_config_pkg::LOGIC_REGULATOR_LEVEL_OFS: rdata_next = {6'h00, level_reg};
        bias_config_pkg::LOGIC_REGULATOR_STARTUP_DELAY_OFS: rdata_next = {4'h0, delay_reg};
        default: rdata_next = 8'h00;
      endcase
    end
    active_next = access_ok;
    // rail-disable masked out of the save image
    save_next = config_next & ~(8'h01 << bias_config_pkg::ANALOG_RAILS_DISABLE_BIT);
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= bias_config_pkg::MISC_CONFIGURATION_RST;
      level_reg <= bias_config_pkg::LOGIC_REGULATOR_LEVEL_RST;
      delay_reg <= bias_config_pkg::LOGIC_REGULATOR_STARTUP_DELAY_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      active_reg <= 1'b1;
      save_reg <= bias_config_pkg::MISC_CONFIGURATION_RST;
    end else begin
      config_reg <= config_next;
      level_reg <= level_next;
      delay_reg <= delay_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      active_reg <= active_next;
      save_reg <= save_next;
    end
  end

  // ----------------------------------------------------------------------
  // control outputs, registered from the fields
  // ----------------------------------------------------------------------
  logic rails_on_reg, dis_reg, dim_reg, thr_reg;
  logic [1:0] lvl_out_reg;

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rails_on_reg <= 1'b1;
      dis_reg <= 1'b0;
      dim_reg <= 1'b1;
      thr_reg <= 1'b0;
      lvl_out_reg <= bias_config_pkg::LOGIC_REGULATOR_LEVEL_RST;
    end else begin
      rails_on_reg <= !config_reg[bias_config_pkg::ANALOG_RAILS_DISABLE_BIT];
      dis_reg <= config_reg[bias_config_pkg::DISCHARGE_INHIBIT_BIT];
      dim_reg <= config_reg[bias_config_pkg::DIMMING_SELECT_BIT];
      thr_reg <= config_reg[bias_config_pkg::RESET_THRESHOLD_SELECT_BIT];
      lvl_out_reg <= level_reg;
    end
  end

  // ----------------------------------------------------------------------
  // regulator start-up sequencer
  // ----------------------------------------------------------------------
  bias_config_pkg::seq_state_t seq_reg, seq_next;
  logic [31:0] tick_reg, tick_next;
  logic [3:0] steps_reg, steps_next;
  logic reg_en_reg, reg_en_next;

  // one load cycle lets any nonvolatile reload settle before counting
  always_comb begin
    seq_next = seq_reg;
    tick_next = tick_reg;
    steps_next = steps_reg;
    reg_en_next = reg_en_reg;
    case (seq_reg)
      bias_config_pkg::SEQ_LOAD: begin
        tick_next = 32'h0;
        steps_next = 4'h0;
        reg_en_next = 1'b0;
        if (supply_good && !NV_LOAD_I) begin
          seq_next = bias_config_pkg::SEQ_WAIT;
        end
      end
      bias_config_pkg::SEQ_WAIT: begin
        if (!supply_good) begin
          seq_next = bias_config_pkg::SEQ_LOAD;
        end else if (steps_reg == delay_reg) begin
          reg_en_next = 1'b1;
          seq_next = bias_config_pkg::SEQ_RUN;
        end else if (tick_reg == 32'(STEP_CYCLES - 1)) begin
          tick_next = 32'h0;
          steps_next = steps_reg + 4'h1;
        end else begin
          tick_next = tick_reg + 32'h1;
        end
      end
      bias_config_pkg::SEQ_RUN: begin
        // supply loss drops the regulator and restarts the delay
        if (!supply_good) begin
          reg_en_next = 1'b0;
          seq_next = bias_config_pkg::SEQ_LOAD;
        end
      end
      default: seq_next = bias_config_pkg::SEQ_LOAD;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= bias_config_pkg::SEQ_LOAD;
      tick_reg <= 32'h0;
      steps_reg <= 4'h0;
      reg_en_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      tick_reg <= tick_next;
      steps_reg <= steps_next;
      reg_en_reg <= reg_en_next;
    end
  end

  assign RDATA_O = rdata_reg;
  assign RDATA_VALID_O = rvalid_reg;
  assign BUS_ACTIVE_O = active_reg;
  assign SAVE_DATA_O = save_reg;
  assign BOOST1_ENABLE_O = rails_on_reg;
  assign BOOST2_ENABLE_O = rails_on_reg;
  assign CHARGE_PUMP_ENABLE_O = rails_on_reg;
  assign DISCHARGE_INHIBIT_O = dis_reg;
  assign DIMMING_SELECT_O = dim_reg;
  assign RESET_THRESHOLD_SELECT_O = thr_reg;
  assign LEVEL_SELECT_O = lvl_out_reg;
  assign REGULATOR_ENABLE_O = reg_en_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  // register bus and save image
  save_no_rails_a: assert property (!SAVE_DATA_O[7]) else $error("rail bit saved");
  load_clears_a: assert property (NV_LOAD_I |=> !config_reg[7]) else $error("rail bit kept");
  cfg_write_a: assert property (WR_EN_I && access_ok && !NV_LOAD_I && ADDR_I == 8'h00
    |=> config_reg == $past(WDATA_I)) else $error("config write lost");
  level_write_a: assert property (WR_EN_I && access_ok && !NV_LOAD_I && ADDR_I == 8'h01
    |=> level_reg == $past(WDATA_I[1:0])) else $error("level write lost");
  level_read_a: assert property (RD_EN_I && access_ok && ADDR_I == 8'h01
    |=> RDATA_O[7:2] == 6'h00) else $error("level upper bits set");
  delay_read_a: assert property (RD_EN_I && access_ok && ADDR_I == 8'h02
    |=> RDATA_O[7:4] == 4'h0) else $error("delay upper bits set");
  read_valid_a: assert property (RD_EN_I && access_ok |=> RDATA_VALID_O)
    else $error("read not answered");
  // write protect gates both directions
  protect_block_a: assert property (config_reg[2] && wp_n && WR_EN_I && !NV_LOAD_I
    |=> $stable(config_reg) && $stable(level_reg)) else $error("write not blocked");
  read_refused_a: assert property (RD_EN_I && !access_ok |=> !RDATA_VALID_O)
    else $error("refused read answered");
  // control outputs trail their fields by one cycle
  rails_follow_a: assert property (
    config_reg[7] |=> !BOOST1_ENABLE_O && !BOOST2_ENABLE_O && !CHARGE_PUMP_ENABLE_O)
    else $error("rails not disabled");
  discharge_out_a: assert property (DISCHARGE_INHIBIT_O == $past(config_reg[3]))
    else $error("discharge wrong");
  dim_out_a: assert property (DIMMING_SELECT_O == $past(config_reg[1])) else $error("dim");
  thr_out_a: assert property (RESET_THRESHOLD_SELECT_O == $past(config_reg[0]))
    else $error("threshold wrong");
  level_out_a: assert property (##2 LEVEL_SELECT_O == $past(level_reg)) else $error("lvl");
  // sequencer starts at once on code 0, never starts early, and drops on supply loss
  zero_delay_a: assert property (seq_reg == bias_config_pkg::SEQ_WAIT && delay_reg == 4'h0
    && supply_good |=> REGULATOR_ENABLE_O) else $error("zero delay late");
  no_early_a: assert property (
    seq_reg == bias_config_pkg::SEQ_LOAD |=> !REGULATOR_ENABLE_O)
    else $error("regulator early");
  supply_loss_a: assert property (!supply_good |=> !REGULATOR_ENABLE_O)
    else $error("regulator kept on");

  // main scenarios
  cfg_write_c: cover property (WR_EN_I && access_ok && ADDR_I == 8'h00);
  protect_c: cover property (WR_EN_I && !access_ok);
  start_c: cover property (!REGULATOR_ENABLE_O ##1 REGULATOR_ENABLE_O);
  load_c: cover property (NV_LOAD_I);
  zero_start_c: cover property (seq_reg == bias_config_pkg::SEQ_WAIT && delay_reg == 4'h0);

endmodule // bias_config_regs

`default_nettype wire

// *** host_model.sv ***
/*
  Behavioural host on the byte-wide register port of the bias register bank.
  Assumes one shared clock; strobes are one-cycle pulses launched after an edge.
*/
`default_nettype none

module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic valid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // idle bus
  // ----------------------------------------------------------------------
  // idle address and data carry junk, never a stale copy
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h5A;
    wdata_o = 8'hA5;
  end

  // one write strobe; reserved configuration bits always go out as zero
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == 8'h00) ? (d & 8'h8F) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~wdata_o;
  endtask

  // one read strobe; answer expected the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    ok = (valid_i === 1'b1);
    d = rdata_i;
  endtask
endmodule // host_model

`default_nettype wire

// *** tb_top.sv ***
/*
  Self-checking bench for the bias register bank with a behavioural host.
  Assumes a short start-up step (4 cycles) and a 250 MHz clock.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n, supply, nv_load, wr, rd, ok, valid, bus_act, b1, b2, cp;
  logic dis, dim, thr, reg_en;
  logic [7:0] addr, wdata, rdata, save, nv_cfg, nv_lvl, nv_dly, d, cfg_m;
  logic [1:0] lvl, lvl_m;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  // address, write data, expected read back
  logic [23:0] rows [0:8] = '{24'h01FF03, 24'h010000, 24'h010202, 24'h02FF0F,
    24'h020303, 24'h035500, 24'h000000, 24'h000909, 24'h008383};

  always #2 clk = ~clk;

  host_model u_host (.clk_i(clk), .rdata_i(rdata), .valid_i(valid), .wr_o(wr),
    .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  bias_config_regs #(.STEP_CYCLES(4)) u_dut (.CLK_I(clk), .RESET_N_I(rst_n),
    .WRITE_PROTECT_N_I(wp_n), .SUPPLY_GOOD_I(supply), .WR_EN_I(wr), .RD_EN_I(rd),
    .ADDR_I(addr), .WDATA_I(wdata), .NV_LOAD_I(nv_load), .NV_CONFIG_I(nv_cfg),
    .NV_LEVEL_I(nv_lvl), .NV_DELAY_I(nv_dly), .RDATA_O(rdata), .RDATA_VALID_O(valid),
    .BUS_ACTIVE_O(bus_act), .SAVE_DATA_O(save), .BOOST1_ENABLE_O(b1),
    .BOOST2_ENABLE_O(b2), .CHARGE_PUMP_ENABLE_O(cp), .DISCHARGE_INHIBIT_O(dis),
    .DIMMING_SELECT_O(dim), .RESET_THRESHOLD_SELECT_O(thr), .LEVEL_SELECT_O(lvl),
    .REGULATOR_ENABLE_O(reg_en));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [7:0] e);
    u_host.read_reg(a, d, ok);
    chk("valid", 8'h01, {7'h00, ok});
    chk("rdata", e, d);
  endtask

  // outputs follow the shadow copy of the fields
  task automatic check_outs();
    chk("boost1", {7'h00, ~cfg_m[7]}, {7'h00, b1});
    chk("boost2", {7'h00, ~cfg_m[7]}, {7'h00, b2});
    chk("pump", {7'h00, ~cfg_m[7]}, {7'h00, cp});
    chk("discharge", {7'h00, cfg_m[3]}, {7'h00, dis});
    chk("dimming", {7'h00, cfg_m[1]}, {7'h00, dim});
    chk("threshold", {7'h00, cfg_m[0]}, {7'h00, thr});
    chk("level", {6'h00, lvl_m}, {6'h00, lvl});
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cfg_m = 8'h02;
    lvl_m = 2'h3;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    wp_n = 1'b1;
    supply = 1'b0;
    nv_load = 1'b0;
    nv_cfg = 8'h8B;
    nv_lvl = 8'h01;
    nv_dly = 8'h01;
    do_reset();
    read_chk(8'h00, 8'h02);
    read_chk(8'h01, 8'h03);
    read_chk(8'h02, 8'h02);
    chk("save", 8'h02, save);
    chk("bus_active", 8'h01, {7'h00, bus_act});
    check_outs();
    foreach (rows[i]) begin
      u_host.write_reg(rows[i][23:16], rows[i][15:8]);
      read_chk(rows[i][23:16], rows[i][7:0]);
      if (rows[i][23:16] == 8'h00) cfg_m = rows[i][7:0];
      if (rows[i][23:16] == 8'h01) lvl_m = rows[i][1:0];
      check_outs();
    end
    chk("save", 8'h03, save);
    // protected: pin high blocks both writes and reads
    u_host.write_reg(8'h00, 8'h04);
    repeat (2) @(posedge clk);
    chk("bus_active", 8'h00, {7'h00, bus_act});
    u_host.write_reg(8'h01, 8'h00);
    u_host.read_reg(8'h01, d, ok);
    chk("refused", 8'h00, {7'h00, ok});
    wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    read_chk(8'h01, 8'h02);
    // saved image reload never brings rail-disable back
    @(posedge clk);
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    read_chk(8'h00, 8'h0B);
    read_chk(8'h01, 8'h01);
    read_chk(8'h02, 8'h01);
    cfg_m = 8'h0B;
    lvl_m = 2'h1;
    check_outs();
    // regulator start waits code 3 steps of 4 cycles plus sync
    u_host.write_reg(8'h02, 8'h03);
    @(posedge clk);
    supply <= 1'b1;
    n = 0;
    while (reg_en !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("reg_delay", 8'h01, {7'h00, (n >= 12 && n <= 20)});
    supply <= 1'b0;
    repeat (6) @(posedge clk);
    chk("reg_off", 8'h00, {7'h00, reg_en});
    // code 0 starts the regulator right after the synchronised supply
    u_host.write_reg(8'h02, 8'h00);
    @(posedge clk);
    supply <= 1'b1;
    n = 0;
    while (reg_en !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("reg_zero", 8'h01, {7'h00, (n >= 2 && n <= 8)});
    supply <= 1'b0;
    repeat (6) @(posedge clk);
    // rail-disable set, then lost at power-up
    u_host.write_reg(8'h00, 8'h80);
    repeat (2) @(posedge clk);
    chk("boost1", 8'h00, {7'h00, b1});
    do_reset();
    read_chk(8'h00, 8'h02);
    chk("boost1", 8'h01, {7'h00, b1});
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
